// ===== rtl/cie_pkg.sv
// constants and types of the capture input edge block
package cie_pkg;
	localparam int          cnt_w          = 16;
	localparam int          addr_w         = 8;
	localparam int          div_w          = 4;
	localparam logic [7:0]  ctrl_offset    = 8'h00;
	localparam logic [7:0]  status_offset  = 8'h04;
	localparam logic [7:0]  cap_first_off  = 8'h08;
	localparam logic [7:0]  cap_second_off = 8'h0c;
	localparam logic [7:0]  counter_offset = 8'h10;
	localparam int          run_pos        = 0;
	localparam int          reverse_pos    = 1;
	localparam int          pin_clock_pos  = 2;
	localparam int          presc_pos      = 3;
	localparam int          edge_first_pos = 5;
	localparam int          edge_sec_pos   = 7;
	localparam logic [8:0]  ctrl_reset     = 9'h000;
	localparam logic [1:0]  resp_okay      = 2'h0;
	localparam logic [1:0]  resp_slverr    = 2'h2;

	typedef enum logic [1:0] {
		edge_falling = 2'h0,
		edge_rising  = 2'h1,
		edge_both    = 2'h2,
		edge_none    = 2'h3
	} cie_edge_type;

	typedef struct packed {
		cie_edge_type edge_second;
		cie_edge_type edge_first;
		logic [1:0]   prescaler_select;
		logic         pin_clock;
		logic         reverse_phase_capture_bit;
		logic         run;
	} cie_ctrl_type;

	typedef struct packed {
		logic cap;
		logic irq;
	} cie_req_type;
endpackage : cie_pkg

// ===== rtl/cie_capture.sv
// capture input edge logic of a 16-bit timer with an axi4-lite register slave
// Contract
// - capture counter on count clock falling edge
// - interrupt on following count clock rising edge
// - reverse mode: opposite edge captures, no interrupt
// - reverse mode: second pin only raises interrupt
// - first enable after reset: high is rising
// - re-enable after stop: high is no edge
// - pin clock mode: first pin filter samples every cycle, second pin on count clock
// - capture mode: filter samples on count clock
// - edge needs two equal consecutive samples
// - pins ignored while timer stopped
`timescale 1ns/1ps
module cie_capture #(
	parameter int CNT_W = cie_pkg::cnt_w
) (
	input  wire logic                       clock,
	input  wire logic                       rst_b,
	input  wire logic                       trigger_pin_first,
	input  wire logic                       trigger_pin_second,
	output logic                            capture_irq_first,
	output logic                            capture_irq_second,
	input  wire logic [cie_pkg::addr_w-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [cie_pkg::addr_w-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready
);
	import cie_pkg::*;

	function automatic logic edge_hit(cie_edge_type sel, logic rise, logic fall);
		unique case (sel)
			edge_falling: edge_hit = fall;
			edge_rising:  edge_hit = rise;
			edge_both:    edge_hit = rise | fall;
			edge_none:    edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

	cie_ctrl_type         ctrl;
	logic [1:0]           sync_a;
	logic [1:0]           sync_b;
	logic [1:0]           sync_c;
	logic [1:0]           level;
	logic [1:0]           sample_prev;
	logic [1:0]           filt;
	logic [1:0]           next_sample_prev;
	logic [1:0]           next_filt;
	logic [1:0]           rise;
	logic [1:0]           fall;
	logic [1:0]           sample_en;
	logic                 run_q;
	logic                 started_once;
	logic                 start;
	logic [div_w-1:0]     div_cnt;
	logic [div_w-1:0]     next_div_cnt;
	logic [div_w-1:0]     div_mask;
	logic [div_w-1:0]     div_half;
	logic                 cc_rise;
	logic                 cc_fall;
	logic [CNT_W-1:0]     wide_counter;
	logic [CNT_W-1:0]     next_wide_counter;
	logic [CNT_W-1:0]     capture_reg_first;
	logic [CNT_W-1:0]     capture_reg_second;
	logic [CNT_W-1:0]     next_cap_first;
	logic [CNT_W-1:0]     next_cap_second;
	cie_req_type          req_first;
	cie_req_type          req_second;
	cie_req_type          pend_first;
	cie_req_type          pend_second;
	cie_req_type          next_pend_first;
	cie_req_type          next_pend_second;
	logic                 due_first;
	logic                 due_second;
	logic                 next_due_first;
	logic                 next_due_second;
	logic                 valid_first;
	logic                 valid_second;
	logic                 opposite_first;

	// pins cross into the clock domain; a level counts once stages b and c agree
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync_a <= 2'h0;
			sync_b <= 2'h0;
			sync_c <= 2'h0;
			level  <= 2'h0;
		end else begin
			sync_a <= {trigger_pin_second, trigger_pin_first};
			sync_b <= sync_a;
			sync_c <= sync_b;
			for (int i = 0; i < 2; i++) begin
				if (sync_b[i] == sync_c[i]) begin
					level[i] <= sync_b[i];
				end
			end
		end
	end

	// count clock divider: period 2 << prescaler_select
	always_comb begin
		div_mask     = div_w'((5'h02 << ctrl.prescaler_select) - 5'h01);
		div_half     = div_w'(5'h01 << ctrl.prescaler_select);
		cc_rise      = ctrl.run && ((div_cnt & div_mask) == '0);
		cc_fall      = ctrl.run && ((div_cnt & div_mask) == div_half);
		next_div_cnt = ctrl.run ? div_cnt + 1'b1 : '0;
		start        = ctrl.run & ~run_q;
	end

	// noise filter and edge detector
	always_comb begin
		sample_en[0] = ctrl.pin_clock ? ctrl.run : cc_rise;
		sample_en[1] = cc_rise;
		next_sample_prev = sample_prev;
		next_filt        = filt;
		rise             = 2'h0;
		fall             = 2'h0;
		for (int i = 0; i < 2; i++) begin
			if (start) begin
				if (started_once) begin
					next_sample_prev[i] = level[i];
					next_filt[i]        = level[i];
				end
			end else if (ctrl.run && sample_en[i]) begin
				next_sample_prev[i] = level[i];
				if (level[i] == sample_prev[i] && level[i] != filt[i]) begin
					next_filt[i] = level[i];
					rise[i]      = level[i];
					fall[i]      = ~level[i];
				end
			end
		end
	end

	// filter starts low after reset so a high pin reads as a rising edge
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sample_prev  <= 2'h0;
			filt         <= 2'h0;
			run_q        <= 1'b0;
			started_once <= 1'b0;
			div_cnt      <= '0;
		end else begin
			sample_prev  <= next_sample_prev;
			filt         <= next_filt;
			run_q        <= ctrl.run;
			started_once <= started_once | start;
			div_cnt      <= next_div_cnt;
		end
	end

	// edge to capture requests; pin 1 is no capture trigger while it clocks the counter
	always_comb begin
		valid_first    = edge_hit(ctrl.edge_first, rise[0], fall[0]);
		valid_second   = edge_hit(ctrl.edge_second, rise[1], fall[1]);
		opposite_first = (ctrl.edge_first == edge_falling) ? rise[0] :
			(ctrl.edge_first == edge_rising) ? fall[0] : 1'b0;
		req_first  = '{cap: 1'b0, irq: 1'b0};
		req_second = '{cap: 1'b0, irq: 1'b0};
		if (ctrl.reverse_phase_capture_bit) begin
			req_first.cap  = opposite_first & ~ctrl.pin_clock;
			req_first.irq  = valid_second;
			req_second.cap = valid_first & ~ctrl.pin_clock;
			req_second.irq = valid_first & ~ctrl.pin_clock;
		end else begin
			req_first.cap  = valid_first & ~ctrl.pin_clock;
			req_first.irq  = valid_first & ~ctrl.pin_clock;
			req_second.cap = valid_second;
			req_second.irq = valid_second;
		end
	end

	// capture and interrupt timing
	always_comb begin
		next_pend_first   = pend_first;
		next_pend_second  = pend_second;
		next_due_first    = due_first & ~cc_rise;
		next_due_second   = due_second & ~cc_rise;
		next_cap_first    = capture_reg_first;
		next_cap_second   = capture_reg_second;
		next_wide_counter = wide_counter;
		if (ctrl.pin_clock ? valid_first : cc_rise) begin
			next_wide_counter = wide_counter + 1'b1;
		end
		if (cc_fall) begin
			if (pend_first.cap) begin
				next_cap_first = wide_counter;
			end
			if (pend_second.cap) begin
				next_cap_second = wide_counter;
			end
			next_due_first   = pend_first.irq;
			next_due_second  = pend_second.irq;
			next_pend_first  = '{cap: 1'b0, irq: 1'b0};
			next_pend_second = '{cap: 1'b0, irq: 1'b0};
		end
		// a new edge in the capture cycle stays pending for the next falling edge
		next_pend_first  = next_pend_first | req_first;
		next_pend_second = next_pend_second | req_second;
		if (!ctrl.run) begin
			next_wide_counter = '0;
			next_pend_first   = '{cap: 1'b0, irq: 1'b0};
			next_pend_second  = '{cap: 1'b0, irq: 1'b0};
			next_due_first    = 1'b0;
			next_due_second   = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wide_counter       <= '0;
			capture_reg_first  <= '0;
			capture_reg_second <= '0;
			pend_first         <= '{cap: 1'b0, irq: 1'b0};
			pend_second        <= '{cap: 1'b0, irq: 1'b0};
			due_first          <= 1'b0;
			due_second         <= 1'b0;
			capture_irq_first  <= 1'b0;
			capture_irq_second <= 1'b0;
		end else begin
			wide_counter       <= next_wide_counter;
			capture_reg_first  <= next_cap_first;
			capture_reg_second <= next_cap_second;
			pend_first         <= next_pend_first;
			pend_second        <= next_pend_second;
			due_first          <= next_due_first;
			due_second         <= next_due_second;
			capture_irq_first  <= due_first & cc_rise;
			capture_irq_second <= due_second & cc_rise;
		end
	end

	// axi4-lite slave: address and data held separately, then one write
	logic                aw_hold;
	logic                w_hold;
	logic [addr_w-1:0]   awaddr_q;
	logic [31:0]         wdata_q;
	logic [3:0]          wstrb_q;
	logic                next_aw_hold;
	logic                next_w_hold;
	logic [addr_w-1:0]   next_awaddr;
	logic [31:0]         next_wdata;
	logic [3:0]          next_wstrb;
	logic                next_bvalid;
	logic [1:0]          next_bresp;
	logic                next_rvalid;
	logic [1:0]          next_rresp;
	logic [31:0]         next_rdata;
	cie_ctrl_type        next_ctrl;
	logic [8:0]          ctrl_bits;

	always_comb begin
		next_aw_hold = aw_hold;
		next_w_hold  = w_hold;
		next_awaddr  = awaddr_q;
		next_wdata   = wdata_q;
		next_wstrb   = wstrb_q;
		next_bvalid  = s_axi_bvalid & ~s_axi_bready;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid & ~s_axi_rready;
		next_rresp   = s_axi_rresp;
		next_rdata   = s_axi_rdata;
		next_ctrl    = ctrl;
		ctrl_bits    = ctrl;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_hold = 1'b1;
			next_awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_hold = 1'b1;
			next_wdata  = s_axi_wdata;
			next_wstrb  = s_axi_wstrb;
		end
		if (aw_hold && w_hold && !s_axi_bvalid) begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = resp_okay;
			unique case (awaddr_q)
				ctrl_offset: begin
					if (wstrb_q[0]) begin
						ctrl_bits[7:0] = wdata_q[7:0];
					end
					if (wstrb_q[1]) begin
						ctrl_bits[8] = wdata_q[edge_sec_pos+1];
					end
					next_ctrl = cie_ctrl_type'(ctrl_bits);
				end
				status_offset, cap_first_off, cap_second_off, counter_offset: begin
				end
				default: next_bresp = resp_slverr;
			endcase
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = resp_okay;
			next_rdata  = 32'h0000_0000;
			unique case (s_axi_araddr)
				ctrl_offset:    next_rdata[8:0] = ctrl;
				status_offset:  next_rdata[3:0] = {started_once, filt, ctrl.run};
				cap_first_off:  next_rdata[CNT_W-1:0] = capture_reg_first;
				cap_second_off: next_rdata[CNT_W-1:0] = capture_reg_second;
				counter_offset: next_rdata[CNT_W-1:0] = wide_counter;
				default:        next_rresp = resp_slverr;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			aw_hold       <= 1'b0;
			w_hold        <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= resp_okay;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= resp_okay;
			s_axi_rdata   <= 32'h0000_0000;
			ctrl          <= cie_ctrl_type'(ctrl_reset);
		end else begin
			aw_hold       <= next_aw_hold;
			w_hold        <= next_w_hold;
			awaddr_q      <= next_awaddr;
			wdata_q       <= next_wdata;
			wstrb_q       <= next_wstrb;
			s_axi_awready <= ~next_aw_hold & ~next_bvalid;
			s_axi_wready  <= ~next_w_hold & ~next_bvalid;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= ~next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rresp   <= next_rresp;
			s_axi_rdata   <= next_rdata;
			ctrl          <= next_ctrl;
		end
	end
endmodule : cie_capture

// ===== sim/cie_capture_checker.sv
// assertion checker bound to the capture input edge block
`timescale 1ns/1ps
module cie_capture_checker (
	input wire logic                       clock,
	input wire logic                       rst_b,
	input wire logic                       capture_irq_first,
	input wire logic                       capture_irq_second,
	input wire logic [cie_pkg::addr_w-1:0] s_axi_awaddr,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic [31:0]                s_axi_wdata,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready
);
	import cie_pkg::*;
	cie_ctrl_type ctl;
	cie_ctrl_type next_ctl;
	logic         irq_any;
	assign irq_any = capture_irq_first | capture_irq_second;
	// shadow of the control word; assumes full strobes and aw with w together
	always_comb begin
		next_ctl = ctl;
		if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == ctrl_offset) begin
			next_ctl = cie_ctrl_type'(s_axi_wdata[8:0]);
		end
	end
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctl <= cie_ctrl_type'(ctrl_reset);
		end else begin
			ctl <= next_ctl;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_stopped;
		(!ctl.run) [*3];
	endsequence
	sequence s_no_edges;
		(ctl.edge_first == edge_none && ctl.edge_second == edge_none) [*3];
	endsequence
	AST_STOP_QUIET: assert property (s_stopped |-> !irq_any)
		else $error("irq while stopped");
	AST_IRQ1_PULSE: assert property (capture_irq_first |=> !capture_irq_first)
		else $error("first irq longer than one cycle");
	AST_IRQ2_PULSE: assert property (capture_irq_second |=> !capture_irq_second)
		else $error("second irq longer than one cycle");
	AST_NO_EDGE_QUIET: assert property (s_no_edges |-> !irq_any)
		else $error("irq with no valid edge chosen");
	AST_REV_NO_SECOND: assert property (
		(ctl.reverse_phase_capture_bit && ctl.edge_first == edge_none) [*3]
		|-> !capture_irq_second) else $error("second irq from second pin in reverse mode");
	AST_REV_OPP_QUIET: assert property (
		(ctl.reverse_phase_capture_bit && ctl.edge_second == edge_none) [*3]
		|-> !capture_irq_first) else $error("first irq from opposite edge capture");
	AST_PINCLK_QUIET: assert property (
		(ctl.pin_clock && !ctl.reverse_phase_capture_bit && ctl.edge_second == edge_none) [*3]
		|-> !capture_irq_first) else $error("first irq while first pin clocks counter");
	AST_START_FILTER: assert property ($rose(ctl.run) |-> (!irq_any) [*4])
		else $error("irq sooner than two filter samples");
endmodule : cie_capture_checker

bind cie_capture cie_capture_checker i_cie_capture_checker (.clock, .rst_b,
	.capture_irq_first, .capture_irq_second, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready);

// ===== sim/cie_trig_src.sv
// behavioural source of the two external trigger pins
`timescale 1ns/1ps
module cie_trig_src (
	input  wire logic clock,
	input  wire logic want_first,
	input  wire logic want_second,
	output logic      trigger_pin_first,
	output logic      trigger_pin_second
);
	logic [1:0] pins = 2'h0;
	logic [1:0] next_pins;
	// pulse width held
	// levels last as long as the bench asks; only the glitch and pin clock cases go short
	always_comb begin
		next_pins = {want_first, want_second};
	end
	always_ff @(posedge clock) begin
		pins <= next_pins;
	end
	assign trigger_pin_first = pins[1];
	assign trigger_pin_second = pins[0];
endmodule : cie_trig_src

// ===== sim/cie_capture_tb.sv
// self-checking bench for the capture input edge block
`timescale 1ns/1ps
module cie_capture_tb;
	import cie_pkg::*;
	logic        clock = 1'b0;
	logic        rst_b = 1'b0;
	logic        want_first = 1'b0;
	logic        want_second = 1'b0;
	logic        trigger_pin_first, trigger_pin_second, capture_irq_first, capture_irq_second;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, rd0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	int          n_errors = 0;
	int          cmp_count = 0;

	always #5 clock = ~clock;

	cie_capture i_cie_capture (.clock, .rst_b, .trigger_pin_first, .trigger_pin_second,
		.capture_irq_first, .capture_irq_second, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	cie_trig_src i_cie_trig_src (.clock, .want_first, .want_second, .trigger_pin_first,
		.trigger_pin_second);

	task final_report;
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task tmo;
		n_errors++;
		$display("[ERR] bus handshake expected answer seen none");
		final_report;
	endtask : tmo

	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && i < 50);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i >= 50) tmo;
	endtask : wr

	task rdr(input logic [7:0] a);
		int i;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && i < 50);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i >= 50) tmo;
	endtask : rdr

	// stop first so the edge choice never changes while running
	task cfg(input logic [31:0] v);
		wr(ctrl_offset, 32'h0, rs);
		wr(ctrl_offset, v, rs);
		chk("ctrl_resp", {30'h0, resp_okay}, {30'h0, rs});
	endtask : cfg

	task watch(input logic e1, input logic e2);
		logic s1, s2;
		s1 = 1'b0;
		s2 = 1'b0;
		repeat (120) begin
			@(posedge clock);
			#1;
			s1 = s1 | (capture_irq_first === 1'b1);
			s2 = s2 | (capture_irq_second === 1'b1);
		end
		chk("irq_first", {31'h0, e1}, {31'h0, s1});
		chk("irq_second", {31'h0, e2}, {31'h0, s2});
	endtask : watch

	task step(input logic f, input logic s, input logic e1, input logic e2);
		@(posedge clock);
		want_first <= f;
		want_second <= s;
		watch(e1, e2);
	endtask : step

	// sixteen cycles: one whole count clock at the slowest prescale, so one sample sees it
	task pulse(input logic f, input logic s);
		@(posedge clock);
		want_first <= f;
		want_second <= s;
		repeat (16) @(posedge clock);
		want_first <= 1'b0;
		want_second <= 1'b0;
	endtask : pulse

	task t_regs;
		rdr(ctrl_offset);
		chk("ctrl_reset", 32'h0, rd);
		rdr(8'h14);
		chk("unmapped_rd", {30'h0, resp_slverr}, {30'h0, rs});
		wr(8'h14, 32'h1, rs);
		chk("unmapped_wr", {30'h0, resp_slverr}, {30'h0, rs});
		wr(status_offset, 32'hf, rs);
		chk("ro_wr", {30'h0, resp_okay}, {30'h0, rs});
		rdr(status_offset);
		chk("status", 32'h0, rd);
		$display("test regs done");
	endtask : t_regs

	task t_first;
		step(1'b1, 1'b0, 1'b0, 1'b0);
		cfg(32'h1a1);
		watch(1'b1, 1'b0);
		cfg(32'h1a1);
		watch(1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b0, 1'b0);
		rdr(counter_offset);
		rd0 = rd;
		step(1'b1, 1'b0, 1'b1, 1'b0);
		rdr(cap_first_off);
		chk("cap_first_late", 32'h1, {31'h0, rd > rd0});
		step(1'b0, 1'b0, 1'b0, 1'b0);
		$display("test first enable done");
	endtask : t_first

	task t_edges;
		for (int c = 0; c < 3; c++) begin
			cfg(32'h61 | (32'(c) << 7) | (32'(c) << 3));
			step(1'b0, 1'b1, 1'b0, c != 0);
			step(1'b0, 1'b0, 1'b0, c != 1);
		end
		$display("test edges done");
	endtask : t_edges

	task t_glitch;
		cfg(32'hb9);
		pulse(1'b1, 1'b1);
		watch(1'b0, 1'b0);
		step(1'b1, 1'b1, 1'b1, 1'b1);
		step(1'b0, 1'b0, 1'b0, 1'b0);
		$display("test glitch done");
	endtask : t_glitch

	task t_reverse;
		cfg(32'h1a3);
		step(1'b1, 1'b0, 1'b0, 1'b1);
		rdr(cap_first_off);
		rd0 = rd;
		step(1'b0, 1'b0, 1'b0, 1'b0);
		rdr(cap_first_off);
		chk("cap_first_moved", 32'h1, {31'h0, rd !== rd0});
		cfg(32'he3);
		rdr(cap_second_off);
		rd0 = rd;
		step(1'b0, 1'b1, 1'b1, 1'b0);
		rdr(cap_second_off);
		chk("cap_second_kept", rd0, rd);
		step(1'b0, 1'b0, 1'b0, 1'b0);
		$display("test reverse done");
	endtask : t_reverse

	task t_stop_pinclk;
		cfg(32'h140);
		step(1'b1, 1'b1, 1'b0, 1'b0);
		step(1'b0, 1'b0, 1'b0, 1'b0);
		cfg(32'h1bd);
		repeat (3) begin
			pulse(1'b1, 1'b0);
			watch(1'b0, 1'b0);
			step(1'b0, 1'b0, 1'b0, 1'b0);
		end
		rdr(counter_offset);
		chk("pin_count", 32'h3, rd);
		$display("test stop and pin clock done");
	endtask : t_stop_pinclk

	// a second reset must bring back the first-enable behaviour
	task t_reset;
		@(posedge clock);
		rst_b <= 1'b0;
		want_first <= 1'b1;
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		rdr(status_offset);
		chk("status_after_reset", 32'h0, rd);
		cfg(32'h1a1);
		watch(1'b1, 1'b0);
		step(1'b0, 1'b0, 1'b0, 1'b0);
		$display("test mid-run reset done");
	endtask : t_reset

	initial begin
		repeat (3) @(posedge clock);
		rst_b <= 1'b1;
		t_regs;
		t_first;
		t_edges;
		t_glitch;
		t_reverse;
		t_stop_pinclk;
		t_reset;
		final_report;
	end
endmodule : cie_capture_tb
